/* shared/dpdma_pkg.sv */
// constants, field layouts and types of the dual port dma controller
package dpdma_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR_A = 8'h04;
  localparam logic [7:0] OFF_ADDR_B = 8'h08;
  localparam logic [7:0] OFF_LEN    = 8'h0C;
  localparam logic [7:0] OFF_MATCH  = 8'h10;
  localparam logic [7:0] OFF_CMD    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_COUNT  = 8'h1C;
  localparam logic [7:0] OFF_CUR_A  = 8'h20;
  localparam logic [7:0] OFF_CUR_B  = 8'h24;
  localparam logic [7:0] OFF_VECTOR = 8'h28;

  // control register fields
  localparam int CTRL_CLASS_LSB  = 0;
  localparam int CTRL_MODE_LSB   = 2;
  localparam int CTRL_DIR_A2B    = 4;
  localparam int CTRL_A_IO       = 5;
  localparam int CTRL_B_IO       = 6;
  localparam int CTRL_A_RULE_LSB = 7;
  localparam int CTRL_B_RULE_LSB = 9;
  localparam int CTRL_STOP_MATCH = 11;
  localparam int CTRL_INT_MATCH  = 12;
  localparam int CTRL_INT_END    = 13;
  localparam int CTRL_INT_READY  = 14;
  localparam int CTRL_RESTART    = 15;

  // command register bits
  localparam int CMD_ENABLE   = 0;
  localparam int CMD_DISABLE  = 1;
  localparam int CMD_RESET    = 2;
  localparam int CMD_LOAD     = 3;
  localparam int CMD_CONTINUE = 4;
  localparam int CMD_CLR_CNT  = 5;
  localparam int CMD_CLR_STAT = 6;
  localparam int CMD_RD_STAT  = 7;
  localparam int CMD_RD_SEQ   = 8;

  // status register bits
  localparam int ST_READY   = 0;
  localparam int ST_EOB     = 1;
  localparam int ST_MATCH   = 2;
  localparam int ST_INT     = 3;
  localparam int ST_ENABLED = 4;
  localparam int ST_OWNED   = 5;

  // values after reset
  localparam logic [15:0] CTRL_RST  = 16'h0001;
  localparam logic [15:0] LEN_RST   = 16'h0001;
  localparam logic [15:0] MATCH_RST = 16'h0000;
  localparam logic [15:0] VEC_RST   = 16'h0000;
  localparam logic [15:0] ADDR_RST  = 16'h0000;

  typedef enum logic [1:0] {
    DPDMA_CLS_XFER   = 2'h1,
    DPDMA_CLS_SEARCH = 2'h2,
    DPDMA_CLS_BOTH   = 2'h3
  } dpdma_class_e;

  typedef enum logic [1:0] {
    DPDMA_MODE_SINGLE = 2'h0,
    DPDMA_MODE_BURST  = 2'h1,
    DPDMA_MODE_CONT   = 2'h2
  } dpdma_mode_e;

  typedef enum logic [1:0] {
    DPDMA_CNT_DEC   = 2'h0,
    DPDMA_CNT_INC   = 2'h1,
    DPDMA_CNT_FIXED = 2'h2
  } dpdma_cnt_e;

  typedef enum logic [7:0] {
    DPDMA_IDLE = 8'h01,
    DPDMA_REQ  = 8'h02,
    DPDMA_RD1  = 8'h04,
    DPDMA_RD2  = 8'h08,
    DPDMA_WR1  = 8'h10,
    DPDMA_WR2  = 8'h20,
    DPDMA_HOLD = 8'h40,
    DPDMA_REL  = 8'h80
  } dpdma_state_e;
endpackage

/* design/dpdma_addr_gen.sv */
// port address generator with start buffer and fixed/inc/dec counter
`timescale 1ns/100ps
module dpdma_addr_gen #(
  parameter int AW = 16
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // control
  input  wire logic          start_we,
  input  wire logic [AW-1:0] start_wdata,
  input  wire logic          reload,
  input  wire logic          step,
  input  wire logic [1:0]    rule,
  // state
  output logic      [AW-1:0] start_q,
  output logic      [AW-1:0] cur_q
);
  logic [AW-1:0] start_next;
  logic [AW-1:0] cur_next;

  // buffered start value and live counter
  always_comb begin
    start_next = start_we ? start_wdata : start_q;
    cur_next   = cur_q;
    if (reload) begin
      cur_next = start_q;
    end else if (step) begin
      if (rule == dpdma_pkg::DPDMA_CNT_INC) begin
        cur_next = cur_q + AW'(1);
      end else if (rule == dpdma_pkg::DPDMA_CNT_DEC) begin
        cur_next = cur_q - AW'(1);
      end
    end
  end

  // register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      start_q <= AW'(dpdma_pkg::ADDR_RST);
      cur_q   <= AW'(dpdma_pkg::ADDR_RST);
    end else begin
      start_q <= start_next;
      cur_q   <= cur_next;
    end
  end
endmodule

/* design/dpdma_core.sv */
// dual port dma controller: apb registers, bus master fsm, search logic
// How it works
// - transfer, search, or search while transferring
// - takes buses, reads source, writes destination
// - masked compare against programmable match byte
// - search-only compares one byte per two cycles
// - combined class compares every moved byte but the last
// - release buses after each byte once matched, or flag interrupt on chosen conditions
// - single step releases buses after each byte
// - burst stops after byte when ready drops
// - continuous holds buses while ready is low
// - a read byte always finishes its operation
// - byte compare completes after next byte read
// - control writes only off bus, disable block
// - status readable; status commands disable block
// - immediate commands act on the write
// - setting registers hold mode, ports, match, vector
// - status shows ready, end, match, int, counters
// - separate fixed/inc/dec address per port
// - drive buses only after bus acknowledge
// - end-of-block match reflects byte before last
`timescale 1ns/100ps
module dpdma_core (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // system bus arbitration
  output logic             bus_req_n,
  input  wire logic        bus_ack_n,
  input  wire logic        port_ready,
  // system bus
  output logic      [15:0] sys_addr,
  output logic             sys_addr_oe,
  output logic      [7:0]  sys_data_out,
  output logic             sys_data_oe,
  input  wire logic [7:0]  sys_data_in,
  output logic             mreq_n,
  output logic             iorq_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             int_pending
);
  dpdma_pkg::dpdma_state_e st_reg, st_next;
  logic [15:0] ctrl_reg, ctrl_next, len_reg, len_next, match_reg, match_next;
  logic [15:0] vec_reg, vec_next, count_reg, count_next;
  logic [7:0]  buf_reg, buf_next, data_out_next;
  logic        en_reg, en_next, prev_reg, prev_next;
  logic        eob_reg, eob_next, hit_reg, hit_next, int_reg, int_next;
  logic [15:0] addr_next;
  logic        req_n_next, aoe_next, doe_next, mreq_next, iorq_next, rd_next, wr_next;
  logic [31:0] prdata_next;
  logic        pready_next, pslverr_next;
  logic [15:0] start_a, cur_a, start_b, cur_b, src_addr, dst_addr;
  logic        acc, wr_acc, owned, wr_ok, cmd_wr, reload, step_a, step_b;
  logic        has_xfer, has_srch, src_io, dst_io, byte_done, hit_now;
  logic [1:0]  mode;

  // masked compare, mask bit set excludes that bit
  function automatic logic masked_hit(input logic [7:0] d, input logic [15:0] mv);
    masked_hit = ((d ^ mv[7:0]) & ~mv[15:8]) == 8'h00;
  endfunction

  // decode of settings
  assign has_srch = ctrl_reg[dpdma_pkg::CTRL_CLASS_LSB + 1];
  assign has_xfer = ctrl_reg[dpdma_pkg::CTRL_CLASS_LSB +: 2] != dpdma_pkg::DPDMA_CLS_SEARCH;
  assign mode     = ctrl_reg[dpdma_pkg::CTRL_MODE_LSB +: 2];
  assign src_io   = ctrl_reg[dpdma_pkg::CTRL_DIR_A2B] ? ctrl_reg[dpdma_pkg::CTRL_A_IO]
                                                      : ctrl_reg[dpdma_pkg::CTRL_B_IO];
  assign dst_io   = ctrl_reg[dpdma_pkg::CTRL_DIR_A2B] ? ctrl_reg[dpdma_pkg::CTRL_B_IO]
                                                      : ctrl_reg[dpdma_pkg::CTRL_A_IO];
  assign src_addr = ctrl_reg[dpdma_pkg::CTRL_DIR_A2B] ? cur_a : cur_b;
  assign dst_addr = ctrl_reg[dpdma_pkg::CTRL_DIR_A2B] ? cur_b : cur_a;

  // apb access qualification
  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign owned  = st_reg != dpdma_pkg::DPDMA_IDLE;
  assign wr_ok  = wr_acc && !owned && (paddr != dpdma_pkg::OFF_CMD);
  assign cmd_wr = wr_acc && (paddr == dpdma_pkg::OFF_CMD);
  assign reload = cmd_wr && !owned && (pwdata[dpdma_pkg::CMD_LOAD] || pwdata[dpdma_pkg::CMD_RESET]);

  // source steps in rd1 so a read straight after rd2 already sees the next address
  assign step_a = (st_reg == dpdma_pkg::DPDMA_RD1 && ctrl_reg[dpdma_pkg::CTRL_DIR_A2B]) ||
                  (st_reg == dpdma_pkg::DPDMA_WR2 && !ctrl_reg[dpdma_pkg::CTRL_DIR_A2B]);
  assign step_b = (st_reg == dpdma_pkg::DPDMA_RD1 && !ctrl_reg[dpdma_pkg::CTRL_DIR_A2B]) ||
                  (st_reg == dpdma_pkg::DPDMA_WR2 && ctrl_reg[dpdma_pkg::CTRL_DIR_A2B]);

  // end of a byte operation
  assign byte_done = (st_reg == dpdma_pkg::DPDMA_WR2) ||
                     (st_reg == dpdma_pkg::DPDMA_RD2 && !has_xfer);
  assign hit_now   = (st_reg == dpdma_pkg::DPDMA_RD2) && has_srch && prev_reg &&
                     masked_hit(buf_reg, match_reg);

  // port a and b address generators
  dpdma_addr_gen #(.AW(16)) u_addr_a (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .start_we    (wr_ok && paddr == dpdma_pkg::OFF_ADDR_A),
    .start_wdata (pwdata[15:0]),
    .reload      (reload),
    .step        (step_a),
    .rule        (ctrl_reg[dpdma_pkg::CTRL_A_RULE_LSB +: 2]),
    .start_q     (start_a),
    .cur_q       (cur_a)
  );

  dpdma_addr_gen #(.AW(16)) u_addr_b (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .start_we    (wr_ok && paddr == dpdma_pkg::OFF_ADDR_B),
    .start_wdata (pwdata[15:0]),
    .reload      (reload),
    .step        (step_b),
    .rule        (ctrl_reg[dpdma_pkg::CTRL_B_RULE_LSB +: 2]),
    .start_q     (start_b),
    .cur_q       (cur_b)
  );

  // registers, commands, fsm and bus outputs
  always_comb begin
    st_next    = st_reg;
    ctrl_next  = ctrl_reg;
    len_next   = len_reg;
    match_next = match_reg;
    vec_next   = vec_reg;
    count_next = count_reg;
    buf_next   = buf_reg;
    en_next    = en_reg;
    prev_next  = prev_reg;
    eob_next   = eob_reg;
    hit_next   = hit_reg;
    int_next   = int_reg;
    data_out_next = sys_data_out;
    // settings writes, each one disables the block
    if (wr_ok) begin
      en_next = 1'b0;
      unique case (paddr)
        dpdma_pkg::OFF_CTRL:   ctrl_next  = pwdata[15:0];
        dpdma_pkg::OFF_LEN:    len_next   = pwdata[15:0];
        dpdma_pkg::OFF_MATCH:  match_next = pwdata[15:0];
        dpdma_pkg::OFF_VECTOR: vec_next   = pwdata[15:0];
        default: ;
      endcase
    end
    // immediate commands; only disable is taken while on the bus
    if (cmd_wr && owned) begin
      if (pwdata[dpdma_pkg::CMD_DISABLE]) en_next = 1'b0;
    end else if (cmd_wr) begin
      if (pwdata[dpdma_pkg::CMD_ENABLE]) en_next = 1'b1;
      if (pwdata[dpdma_pkg::CMD_DISABLE] || pwdata[dpdma_pkg::CMD_RD_STAT] ||
          pwdata[dpdma_pkg::CMD_RD_SEQ]) en_next = 1'b0;
      if (pwdata[dpdma_pkg::CMD_LOAD] || pwdata[dpdma_pkg::CMD_CLR_CNT] ||
          pwdata[dpdma_pkg::CMD_CONTINUE]) begin
        count_next = 16'h0000;
        prev_next  = 1'b0;
        eob_next   = 1'b0;
      end
      if (pwdata[dpdma_pkg::CMD_CLR_STAT]) begin
        eob_next = 1'b0;
        hit_next = 1'b0;
        int_next = 1'b0;
      end
      if (pwdata[dpdma_pkg::CMD_RESET]) begin
        en_next    = 1'b0;
        ctrl_next  = dpdma_pkg::CTRL_RST;
        count_next = 16'h0000;
        prev_next  = 1'b0;
        eob_next   = 1'b0;
        hit_next   = 1'b0;
        int_next   = 1'b0;
      end
    end
    // bus master sequence
    unique case (st_reg)
      dpdma_pkg::DPDMA_IDLE: begin
        if (en_reg && port_ready && !eob_reg) begin
          st_next = dpdma_pkg::DPDMA_REQ;
          if (ctrl_reg[dpdma_pkg::CTRL_INT_READY]) int_next = 1'b1;
        end
      end
      dpdma_pkg::DPDMA_REQ: begin
        if (!bus_ack_n) st_next = dpdma_pkg::DPDMA_RD1;
      end
      dpdma_pkg::DPDMA_RD1: st_next = dpdma_pkg::DPDMA_RD2;
      dpdma_pkg::DPDMA_RD2: begin
        buf_next  = sys_data_in;
        prev_next = 1'b1;
        data_out_next = sys_data_in;
        if (has_xfer) st_next = dpdma_pkg::DPDMA_WR1;
      end
      dpdma_pkg::DPDMA_WR1: st_next = dpdma_pkg::DPDMA_WR2;
      dpdma_pkg::DPDMA_WR2: ;
      dpdma_pkg::DPDMA_HOLD: begin
        if (!en_reg) st_next = dpdma_pkg::DPDMA_REL;
        else if (port_ready) st_next = dpdma_pkg::DPDMA_RD1;
      end
      dpdma_pkg::DPDMA_REL: st_next = dpdma_pkg::DPDMA_IDLE;
      default: st_next = dpdma_pkg::DPDMA_IDLE;
    endcase
    // match event, set wins over a same-cycle clear
    if (hit_now) begin
      hit_next = 1'b1;
      if (ctrl_reg[dpdma_pkg::CTRL_INT_MATCH]) int_next = 1'b1;
    end
    // byte finished: count, end of block and mode decision
    if (byte_done) begin
      count_next = count_reg + 16'h0001;
      if (count_reg == len_reg) begin
        eob_next = 1'b1;
        if (ctrl_reg[dpdma_pkg::CTRL_INT_END]) int_next = 1'b1;
        st_next = dpdma_pkg::DPDMA_REL;
      end else if ((hit_now || hit_reg) && ctrl_reg[dpdma_pkg::CTRL_STOP_MATCH]) begin
        st_next = dpdma_pkg::DPDMA_REL;
      end else if (!en_reg) begin
        st_next = dpdma_pkg::DPDMA_REL;
      end else if (mode == dpdma_pkg::DPDMA_MODE_BURST) begin
        st_next = port_ready ? dpdma_pkg::DPDMA_RD1 : dpdma_pkg::DPDMA_REL;
      end else if (mode == dpdma_pkg::DPDMA_MODE_CONT) begin
        st_next = port_ready ? dpdma_pkg::DPDMA_RD1 : dpdma_pkg::DPDMA_HOLD;
      end else begin
        st_next = dpdma_pkg::DPDMA_REL;
      end
    end
    // bus pin values for the state being entered
    req_n_next = (st_next == dpdma_pkg::DPDMA_IDLE) || (st_next == dpdma_pkg::DPDMA_REL);
    aoe_next   = st_next inside {dpdma_pkg::DPDMA_RD1, dpdma_pkg::DPDMA_RD2,
                                 dpdma_pkg::DPDMA_WR1, dpdma_pkg::DPDMA_WR2,
                                 dpdma_pkg::DPDMA_HOLD};
    doe_next   = st_next inside {dpdma_pkg::DPDMA_WR1, dpdma_pkg::DPDMA_WR2};
    rd_next    = !(st_next inside {dpdma_pkg::DPDMA_RD1, dpdma_pkg::DPDMA_RD2});
    wr_next    = !(st_next == dpdma_pkg::DPDMA_WR2);
    if (st_next inside {dpdma_pkg::DPDMA_RD1, dpdma_pkg::DPDMA_RD2}) begin
      addr_next = src_addr;
      mreq_next = src_io;
      iorq_next = !src_io;
    end else if (doe_next) begin
      addr_next = dst_addr;
      mreq_next = dst_io;
      iorq_next = !dst_io;
    end else begin
      addr_next = sys_addr;
      mreq_next = 1'b1;
      iorq_next = 1'b1;
    end
    // apb answer one wait state after setup
    pready_next  = psel && penable && !pready;
    pslverr_next = pready_next && pwrite && owned && (paddr != dpdma_pkg::OFF_CMD);
    prdata_next  = 32'h0000_0000;
    if (pready_next && !pwrite) begin
      unique case (paddr)
        dpdma_pkg::OFF_CTRL:   prdata_next[15:0] = ctrl_reg;
        dpdma_pkg::OFF_ADDR_A: prdata_next[15:0] = start_a;
        dpdma_pkg::OFF_ADDR_B: prdata_next[15:0] = start_b;
        dpdma_pkg::OFF_LEN:    prdata_next[15:0] = len_reg;
        dpdma_pkg::OFF_MATCH:  prdata_next[15:0] = match_reg;
        dpdma_pkg::OFF_VECTOR: prdata_next[15:0] = vec_reg;
        dpdma_pkg::OFF_STATUS: prdata_next[5:0] = {owned, en_reg, int_reg, hit_reg,
                                                   eob_reg, port_ready};
        dpdma_pkg::OFF_COUNT:  prdata_next[15:0] = count_reg;
        dpdma_pkg::OFF_CUR_A:  prdata_next[15:0] = cur_a;
        dpdma_pkg::OFF_CUR_B:  prdata_next[15:0] = cur_b;
        default:               pslverr_next = 1'b1;
      endcase
    end else if (pready_next && pwrite) begin
      if (!(paddr inside {dpdma_pkg::OFF_CTRL, dpdma_pkg::OFF_ADDR_A, dpdma_pkg::OFF_ADDR_B,
                          dpdma_pkg::OFF_LEN, dpdma_pkg::OFF_MATCH, dpdma_pkg::OFF_CMD,
                          dpdma_pkg::OFF_VECTOR})) pslverr_next = 1'b1;
    end
  end

  // register all state and every output
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_reg       <= dpdma_pkg::DPDMA_IDLE;
      ctrl_reg     <= dpdma_pkg::CTRL_RST;
      len_reg      <= dpdma_pkg::LEN_RST;
      match_reg    <= dpdma_pkg::MATCH_RST;
      vec_reg      <= dpdma_pkg::VEC_RST;
      count_reg    <= 16'h0000;
      buf_reg      <= 8'h00;
      en_reg       <= 1'b0;
      prev_reg     <= 1'b0;
      eob_reg      <= 1'b0;
      hit_reg      <= 1'b0;
      int_reg      <= 1'b0;
      sys_addr     <= 16'h0000;
      sys_addr_oe  <= 1'b0;
      sys_data_out <= 8'h00;
      sys_data_oe  <= 1'b0;
      bus_req_n    <= 1'b1;
      mreq_n       <= 1'b1;
      iorq_n       <= 1'b1;
      rd_n         <= 1'b1;
      wr_n         <= 1'b1;
      int_pending  <= 1'b0;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
    end else begin
      st_reg       <= st_next;
      ctrl_reg     <= ctrl_next;
      len_reg      <= len_next;
      match_reg    <= match_next;
      vec_reg      <= vec_next;
      count_reg    <= count_next;
      buf_reg      <= buf_next;
      en_reg       <= en_next;
      prev_reg     <= prev_next;
      eob_reg      <= eob_next;
      hit_reg      <= hit_next;
      int_reg      <= int_next;
      sys_addr     <= addr_next;
      sys_addr_oe  <= aoe_next;
      sys_data_out <= data_out_next;
      sys_data_oe  <= doe_next;
      bus_req_n    <= req_n_next;
      mreq_n       <= mreq_next;
      iorq_n       <= iorq_next;
      rd_n         <= rd_next;
      wr_n         <= wr_next;
      int_pending  <= int_next;
      prdata       <= prdata_next;
      pready       <= pready_next;
      pslverr      <= pslverr_next;
    end
  end
endmodule

/* dv/dpdma_core_props.sv */
// concurrent checks on the dma core ports
`timescale 1ns/100ps
module dpdma_core_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // system bus side
  input wire logic        bus_req_n,
  input wire logic        bus_ack_n,
  input wire logic        sys_addr_oe,
  input wire logic        sys_data_oe,
  input wire logic        mreq_n,
  input wire logic        iorq_n,
  input wire logic        rd_n,
  input wire logic        wr_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // setup cycle then first access cycle
  sequence s_access; psel && !penable ##1 psel && penable; endsequence
  // data cycle, one strobe cycle, strobe off
  sequence s_write; wr_n ##1 !wr_n ##1 wr_n; endsequence
  property p_apb_wait; s_access |-> !pready ##1 pready; endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer not in second access cycle");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_err_with_ready; pslverr |-> pready; endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr without pready");
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer cycle");
  property p_ack_first; $rose(sys_addr_oe) |-> !$past(bus_ack_n) && !bus_req_n; endproperty
  a_ack_first: assert property (p_ack_first)
    else $error("bus driven without acknowledge");
  property p_data_addr; sys_data_oe |-> sys_addr_oe && rd_n; endproperty
  a_data_addr: assert property (p_data_addr)
    else $error("data driven without address");
  property p_write; $rose(sys_data_oe) |-> s_write; endproperty
  a_write: assert property (p_write)
    else $error("write strobe shape wrong");
  property p_read_two; $fell(rd_n) |=> !rd_n; endproperty
  a_read_two: assert property (p_read_two)
    else $error("read strobe shorter than two cycles");
  property p_strobe; !rd_n |-> sys_addr_oe && (mreq_n != iorq_n); endproperty
  a_strobe: assert property (p_strobe)
    else $error("read without one port strobe");
  property p_release; $rose(bus_req_n) |-> !sys_addr_oe && !sys_data_oe; endproperty
  a_release: assert property (p_release)
    else $error("drivers still on at release");
endmodule

/* dv/dpdma_host_model.sv */
// host arbiter and shared byte memory on the far side of the dma core
`timescale 1ns/100ps
module dpdma_host_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // arbitration
  input  wire logic        slow,
  input  wire logic        bus_req_n,
  output logic             bus_ack_n,
  // system bus
  input  wire logic [15:0] sys_addr,
  input  wire logic [7:0]  sys_data_out,
  input  wire logic        sys_data_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic      [7:0]  sys_data_in
);
  logic [7:0] mem [256];
  logic [7:0] last_q;
  int         wait_q;
  // grant after a short or long delay, take buses back on release
  always @(posedge core_clk) begin
    if (!reset_n || bus_req_n) begin
      bus_ack_n <= 1'h1;
      wait_q    <= 0;
    end else if (wait_q >= (slow ? 5 : 0)) begin
      bus_ack_n <= 1'h0;
    end else begin
      wait_q <= wait_q + 1;
    end
  end
  // store on write strobe, remember the last byte read
  always @(posedge core_clk) begin
    if (!reset_n) last_q <= 8'h5A;
    else if (!rd_n) last_q <= mem[sys_addr[7:0]];
    if (!wr_n && sys_data_oe) mem[sys_addr[7:0]] <= sys_data_out;
  end
  // released data lines show the inverse of the last byte
  assign sys_data_in = !rd_n ? mem[sys_addr[7:0]] : ~last_q;
endmodule

/* dv/tb.sv */
// self-checking testbench for the dual port dma core
`timescale 1ns/100ps
module tb;
  // design ports
  logic        core_clk, reset_n, psel, penable, pwrite, port_ready;
  logic [7:0]  paddr, sys_data_out, sys_data_in;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, bus_req_n, bus_ack_n, sys_addr_oe, sys_data_oe;
  logic [15:0] sys_addr;
  logic        mreq_n, iorq_n, rd_n, wr_n, int_pending;
  // bench state
  logic        slow, rnd_rdy, prev_req, e;
  logic [31:0] q;
  logic [7:0]  img [256];
  integer      seed, fails, total_checks, cyc, rel;

  dpdma_core u_dpdma_core (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_req_n(bus_req_n), .bus_ack_n(bus_ack_n),
    .port_ready(port_ready), .sys_addr(sys_addr), .sys_addr_oe(sys_addr_oe),
    .sys_data_out(sys_data_out), .sys_data_oe(sys_data_oe), .sys_data_in(sys_data_in),
    .mreq_n(mreq_n), .iorq_n(iorq_n), .rd_n(rd_n), .wr_n(wr_n), .int_pending(int_pending));
  dpdma_host_model u_dpdma_host_model (.core_clk(core_clk), .reset_n(reset_n), .slow(slow),
    .bus_req_n(bus_req_n), .bus_ack_n(bus_ack_n), .sys_addr(sys_addr), .rd_n(rd_n),
    .sys_data_out(sys_data_out), .sys_data_oe(sys_data_oe), .wr_n(wr_n),
    .sys_data_in(sys_data_in));

  // clock
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  // random port ready, bus release count, hang limit
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (rnd_rdy) port_ready <= ($random(seed) % 4) != 0;
    if (bus_req_n === 1'h1 && prev_req === 1'h0) rel = rel + 1;
    prev_req <= bus_req_n;
    if (cyc == 60000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, result left in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) fails = fails + 1;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic cmd(input int b);
    apb(1'h1, dpdma_pkg::OFF_CMD, 32'h1 << b);
  endtask
  function automatic logic exp_match(int sa, int n, logic [7:0] m, logic [7:0] mk);
    for (int i = 0; i < n - 1; i++) if (((img[sa + i] ^ m) & ~mk) == 8'h0) return 1'h1;
    return 1'h0;
  endfunction
  // one whole block, a to b, both incrementing, interrupt at end
  task automatic run(input int cls, input int mode);
    int n, sa, db;
    logic [7:0] m, mk;
    n = 2 + $unsigned($random(seed)) % 7;
    sa = $unsigned($random(seed)) % 64;
    db = 128 + $unsigned($random(seed)) % 64;
    for (int i = 0; i < 256; i++) begin
      img[i] = 8'($random(seed));
      u_dpdma_host_model.mem[i] = img[i];
    end
    m = img[sa + $unsigned($random(seed)) % n];
    mk = 8'($random(seed)) & 8'h0F;
    rnd_rdy = 1'h1;
    apb(1'h1, dpdma_pkg::OFF_CTRL, 32'(cls) | 32'(mode << 2) | 32'h2290);
    apb(1'h1, dpdma_pkg::OFF_ADDR_A, 32'(sa));
    apb(1'h1, dpdma_pkg::OFF_ADDR_B, 32'(db));
    apb(1'h1, dpdma_pkg::OFF_LEN, 32'(n - 1));
    apb(1'h1, dpdma_pkg::OFF_MATCH, {16'h0, mk, m});
    cmd(dpdma_pkg::CMD_LOAD);
    rel = 0;
    cmd(dpdma_pkg::CMD_ENABLE);
    q = 32'h0;
    repeat (300) if (!q[dpdma_pkg::ST_EOB]) apb(1'h0, dpdma_pkg::OFF_STATUS, 32'h0);
    chk("end of block", q[dpdma_pkg::ST_EOB], 1);
    chk("int pending", int_pending, 1);
    if (cls != 1) chk("match", q[dpdma_pkg::ST_MATCH], exp_match(sa, n, m, mk));
    for (int i = 0; i < n; i++)
      chk("dest byte", u_dpdma_host_model.mem[db + i], cls == 2 ? img[db + i] : img[sa + i]);
    if (mode != 1) chk("releases", rel, mode == 0 ? n : 1);
    cmd(dpdma_pkg::CMD_DISABLE);
    cmd(dpdma_pkg::CMD_CLR_STAT);
    chk("int cleared", int_pending, 0);
    $display("test block class %0d mode %0d done", cls, mode);
  endtask
  // port ready drops mid block: burst lets go, continuous holds
  task automatic pause(input int mode);
    int n;
    rnd_rdy = 1'h0;
    port_ready <= 1'h1;
    apb(1'h1, dpdma_pkg::OFF_CTRL, 32'(1 | mode << 2) | 32'h0290);
    apb(1'h1, dpdma_pkg::OFF_LEN, 32'h5);
    cmd(dpdma_pkg::CMD_LOAD);
    cmd(dpdma_pkg::CMD_ENABLE);
    n = 0;
    while (sys_addr_oe !== 1'h1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    port_ready <= 1'h0;
    repeat (12) @(posedge core_clk);
    chk("bus kept", bus_req_n, mode == 1);
    apb(1'h1, dpdma_pkg::OFF_CTRL, 32'h1);
    chk("ctrl refused", e, mode == 2);
    cmd(dpdma_pkg::CMD_DISABLE);
    n = 0;
    while (bus_req_n !== 1'h1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk("bus freed", bus_req_n, 1);
    chk("addr floated", sys_addr_oe, 0);
    apb(1'h0, dpdma_pkg::OFF_STATUS, 32'h0);
    chk("disabled", q[dpdma_pkg::ST_ENABLED], 0);
    $display("test pause mode %0d done", mode);
  endtask

  // main sequence
  initial begin
    seed = 19470;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    rel = 0;
    {reset_n, psel, penable, pwrite, port_ready, slow, rnd_rdy} = 7'h0;
    prev_req = 1'h1;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'h1;
    @(posedge core_clk);
    apb(1'h0, dpdma_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", q, 32'(dpdma_pkg::CTRL_RST));
    apb(1'h0, dpdma_pkg::OFF_LEN, 32'h0);
    chk("len reset", q, 32'(dpdma_pkg::LEN_RST));
    apb(1'h0, 8'h3C, 32'h0);
    chk("unmapped error", e, 1);
    chk("unmapped data", q, 0);
    apb(1'h1, dpdma_pkg::OFF_MATCH, 32'hA53C);
    apb(1'h0, dpdma_pkg::OFF_MATCH, 32'h0);
    chk("match readback", q, 32'hA53C);
    $display("test registers done");
    for (int md = 0; md < 3; md++)
      for (int c = 1; c < 4; c++) begin
        slow <= ~slow;
        run(c, md);
      end
    pause(2);
    pause(1);
    for (int b = dpdma_pkg::CMD_RD_STAT; b <= dpdma_pkg::CMD_RD_SEQ; b++) begin
      cmd(dpdma_pkg::CMD_ENABLE);
      apb(1'h0, dpdma_pkg::OFF_STATUS, 32'h0);
      chk("enabled", q[dpdma_pkg::ST_ENABLED], 1);
      cmd(b);
      apb(1'h0, dpdma_pkg::OFF_STATUS, 32'h0);
      chk("status cmd disables", q[dpdma_pkg::ST_ENABLED], 0);
    end
    cmd(dpdma_pkg::CMD_ENABLE);
    apb(1'h1, dpdma_pkg::OFF_LEN, 32'h3);
    apb(1'h0, dpdma_pkg::OFF_STATUS, 32'h0);
    chk("setting write disables", q[dpdma_pkg::ST_ENABLED], 0);
    $display("test status commands done");
    tally_and_finish();
  end
endmodule

bind dpdma_core dpdma_core_props u_dpdma_core_props (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .bus_req_n(bus_req_n), .bus_ack_n(bus_ack_n), .sys_addr_oe(sys_addr_oe),
  .sys_data_oe(sys_data_oe), .mreq_n(mreq_n), .iorq_n(iorq_n), .rd_n(rd_n), .wr_n(wr_n));
